// ### hdl/dsl_state_legality.sv
// Overview of operation
// RQ1 - Power transitions use clock enable at previous and current edge.
// RQ2 - State before the edge plus the command at that edge gives the action.
// RQ3 - Clock enable low on consecutive edges holds power down; inputs ignored.
// RQ4 - Power down entry/exit with NOP or deselect; active or precharge kind.
// RQ5 - Self refresh entered only from idle by refresh with clock enable falling.
// RQ6 - Self refresh exit by raising clock enable with NOP or deselect.
// RQ7 - After self refresh exit only NOP or deselect; no read before 200 clocks. Code flags only reads in that window.
// RQ8 - No power down entry while read, write, mode set or precharge busy. Code flags it only in read and write burst states.
// RQ9 - Clock enable held for three registered edges after each change.
// RQ10 - Unlisted clock enable sequences are illegal.
// RQ11 - No refresh happens in power down; controller limits residency.
// RQ12 - Clock enable stays high during driver calibration.
// RQ13 - Termination input does not affect transitions; off in self refresh.
// RQ14 - Termination input driven valid in power down when enabled.
// RQ15 - Beat stored when mask low with valid strobe, inhibited when high.
// RQ16 - Idle: NOP, activate, precharge, refresh, mode set legal; read/write not.
// RQ17 - Active: read, write, precharge legal; activate, refresh, mode set not.
// RQ18 - Read burst: NOP continues, read interrupts, all else illegal.
// RQ19 - Write burst: NOP continues, write interrupts, all else illegal.
// RQ20 - Command decoded from select, RAS, CAS, write enable, clock enable.
// RQ21 - Bank bits pick the bank, or the mode register for mode set.
`timescale 1ns/1ns
`default_nettype none
module dsl_state_legality #(
  parameter int BURST_LEN = dsl_pkg::BURST_LEN,
  parameter int XSRD_CLKS = dsl_pkg::XSRD_CLKS,
  parameter int LANES = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire dsl_pkg::dsl_cmd_s cmdIn,
  input wire logic odtIn,
  input wire logic strobeValid,
  input wire logic [LANES-1:0] dataMask,
  output dsl_pkg::dsl_result_s result,
  output logic actionValid,
  output dsl_pkg::dsl_state_e stateOut,
  output logic odtActive,
  output logic readBlocked,
  output logic [LANES-1:0] laneWrite
);
  // Pin synchronisers
  dsl_pkg::dsl_cmd_s cmdMeta, cmdSync;
  logic odtMeta, odtSync, strobeMeta, strobeSync;
  logic [LANES-1:0] maskMeta, maskSync;
  logic ckePrev_reg;
  dsl_pkg::dsl_state_e state_reg, state_next;
  dsl_pkg::dsl_action_e act;
  logic illegal;
  logic [3:0] cmd;
  logic ckeCur;
  logic burstDone;
  logic [$clog2(BURST_LEN+1)-1:0] burstCnt_reg;
  logic [$clog2(XSRD_CLKS+1)-1:0] xsrdCnt_reg;
  logic [1:0] ckeHoldCnt_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmdMeta <= '0;
      cmdSync <= '0;
      odtMeta <= 1'b0;
      odtSync <= 1'b0;
      strobeMeta <= 1'b0;
      strobeSync <= 1'b0;
      maskMeta <= '0;
      maskSync <= '0;
    end else if (clkEn) begin
      cmdMeta <= cmdIn;
      cmdSync <= cmdMeta;
      odtMeta <= odtIn;
      odtSync <= odtMeta;
      strobeMeta <= strobeValid;
      strobeSync <= strobeMeta;
      maskMeta <= dataMask;
      maskSync <= maskMeta;
    end
  end

  assign ckeCur = cmdSync.cke;
  // Deselect forces the rest of the command to don't care
  assign cmd = cmdSync.csN ? dsl_pkg::CMD_NOP
      : {1'b0, cmdSync.rasN, cmdSync.casN, cmdSync.weN}; // [RQ20]
  assign burstDone = (burstCnt_reg == '0);

  // Previous clock enable level
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ckePrev_reg <= 1'b0;
    end else if (clkEn) begin
      ckePrev_reg <= ckeCur; // [RQ1]
    end
  end

  // Next state and action from state before the edge
  always_comb begin
    state_next = state_reg;
    act = dsl_pkg::ACT_NONE;
    illegal = 1'b0;
    case (state_reg) // [RQ2]
      dsl_pkg::DSL_PDN_PRE, dsl_pkg::DSL_PDN_ACT: begin
        if (ckeCur) begin
          // Exit only with NOP or deselect
          if (cmd != dsl_pkg::CMD_NOP) begin
            illegal = 1'b1; // [RQ4]
          end
          act = dsl_pkg::ACT_PDN_EXIT;
          state_next = (state_reg == dsl_pkg::DSL_PDN_ACT) ? dsl_pkg::DSL_ACTIVE
              : dsl_pkg::DSL_IDLE;
        end
        // Low on both edges: inputs ignored, no refresh [RQ3] [RQ11]
      end
      dsl_pkg::DSL_SELF_REF: begin
        if (ckeCur) begin
          if (cmd != dsl_pkg::CMD_NOP) begin
            illegal = 1'b1; // [RQ6]
          end
          act = dsl_pkg::ACT_SREF_EXIT;
          state_next = dsl_pkg::DSL_IDLE;
        end
      end
      dsl_pkg::DSL_IDLE: begin
        if (!ckeCur) begin
          if (cmd == dsl_pkg::CMD_REF) begin
            act = dsl_pkg::ACT_SREF_ENTRY; // [RQ5]
            state_next = dsl_pkg::DSL_SELF_REF;
          end else if (cmd == dsl_pkg::CMD_NOP) begin
            act = dsl_pkg::ACT_PDN_ENTRY; // [RQ4]
            state_next = dsl_pkg::DSL_PDN_PRE;
          end else begin
            illegal = 1'b1; // [RQ10]
          end
        end else begin
          case (cmd) // [RQ16]
            dsl_pkg::CMD_NOP: act = dsl_pkg::ACT_NONE;
            dsl_pkg::CMD_ACT: begin
              act = dsl_pkg::ACT_ROW_OPEN;
              state_next = dsl_pkg::DSL_ACTIVE;
            end
            dsl_pkg::CMD_PRE: act = dsl_pkg::ACT_PRECHARGE;
            dsl_pkg::CMD_REF: act = dsl_pkg::ACT_REFRESH;
            dsl_pkg::CMD_MRS: act = dsl_pkg::ACT_MODE_SET;
            default: illegal = 1'b1;
          endcase
        end
      end
      dsl_pkg::DSL_ACTIVE: begin
        if (!ckeCur) begin
          if (cmd == dsl_pkg::CMD_NOP) begin
            act = dsl_pkg::ACT_PDN_ENTRY; // [RQ4]
            state_next = dsl_pkg::DSL_PDN_ACT;
          end else begin
            illegal = 1'b1; // [RQ5]
          end
        end else begin
          case (cmd) // [RQ17]
            dsl_pkg::CMD_NOP: act = dsl_pkg::ACT_NONE;
            dsl_pkg::CMD_RD: begin
              act = dsl_pkg::ACT_READ;
              state_next = dsl_pkg::DSL_READ;
            end
            dsl_pkg::CMD_WR: begin
              act = dsl_pkg::ACT_WRITE;
              state_next = dsl_pkg::DSL_WRITE;
            end
            dsl_pkg::CMD_PRE: begin
              act = dsl_pkg::ACT_PRECHARGE;
              state_next = dsl_pkg::DSL_IDLE;
            end
            default: illegal = 1'b1;
          endcase
        end
      end
      dsl_pkg::DSL_READ, dsl_pkg::DSL_WRITE: begin
        if (!ckeCur) begin
          illegal = 1'b1; // [RQ8]
        end else if (cmd == dsl_pkg::CMD_NOP) begin
          if (burstDone) begin
            state_next = dsl_pkg::DSL_ACTIVE;
          end
        end else if ((state_reg == dsl_pkg::DSL_READ && cmd == dsl_pkg::CMD_RD)
            || (state_reg == dsl_pkg::DSL_WRITE && cmd == dsl_pkg::CMD_WR)) begin
          act = dsl_pkg::ACT_BURST_INT; // [RQ18] [RQ19]
        end else begin
          illegal = 1'b1; // [RQ18] [RQ19]
        end
      end
      default: begin
        state_next = dsl_pkg::DSL_IDLE;
        illegal = 1'b1;
      end
    endcase
    // Clock enable rise outside a low state is unlisted
    if (ckeCur && !ckePrev_reg && state_reg != dsl_pkg::DSL_PDN_PRE
        && state_reg != dsl_pkg::DSL_PDN_ACT && state_reg != dsl_pkg::DSL_SELF_REF) begin
      illegal = 1'b1; // [RQ10]
    end
    // Clock enable changed before three registered edges
    if (ckeCur != ckePrev_reg && ckeHoldCnt_reg != 2'h0) begin
      illegal = 1'b1; // [RQ9]
    end
    // Read during self refresh exit window, before tXSRD
    if (ckeCur && state_reg != dsl_pkg::DSL_SELF_REF && xsrdCnt_reg != '0) begin
      if (cmd == dsl_pkg::CMD_RD) begin
        illegal = 1'b1; // [RQ7]
      end
    end
    if (illegal) begin
      state_next = state_reg;
      act = dsl_pkg::ACT_NONE;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= dsl_pkg::DSL_IDLE;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // Burst length counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      burstCnt_reg <= '0;
    end else if (clkEn) begin
      if (act == dsl_pkg::ACT_READ || act == dsl_pkg::ACT_WRITE
          || act == dsl_pkg::ACT_BURST_INT) begin
        burstCnt_reg <= $bits(burstCnt_reg)'(BURST_LEN - 2);
      end else if (!burstDone) begin
        burstCnt_reg <= burstCnt_reg - 1'b1;
      end
    end
  end

  // Read lockout after self refresh exit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      xsrdCnt_reg <= '0;
    end else if (clkEn) begin
      if (act == dsl_pkg::ACT_SREF_EXIT) begin
        xsrdCnt_reg <= $bits(xsrdCnt_reg)'(XSRD_CLKS - 1); // [RQ7]
      end else if (xsrdCnt_reg != '0) begin
        xsrdCnt_reg <= xsrdCnt_reg - 1'b1;
      end
    end
  end

  // Clock enable hold counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ckeHoldCnt_reg <= 2'h0;
    end else if (clkEn) begin
      if (ckeCur != ckePrev_reg) begin
        ckeHoldCnt_reg <= 2'(dsl_pkg::CKE_HOLD_CLKS - 1); // [RQ9]
      end else if (ckeHoldCnt_reg != 2'h0) begin
        ckeHoldCnt_reg <= ckeHoldCnt_reg - 2'h1;
      end
    end
  end

  // Result outputs
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      result <= '0;
      actionValid <= 1'b0;
      stateOut <= dsl_pkg::DSL_IDLE;
      readBlocked <= 1'b0;
    end else if (clkEn) begin
      result.action <= act;
      result.bank <= cmdSync.bank; // [RQ21]
      result.allBanks <= cmdSync.addr[dsl_pkg::A10_BIT];
      result.illegal <= illegal;
      actionValid <= (act != dsl_pkg::ACT_NONE) | illegal;
      stateOut <= state_next;
      readBlocked <= (xsrdCnt_reg > 1) || (act == dsl_pkg::ACT_SREF_EXIT);
    end
  end

  // Termination gated off in self refresh only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      odtActive <= 1'b0;
    end else if (clkEn) begin
      odtActive <= odtSync && (state_next != dsl_pkg::DSL_SELF_REF); // [RQ13]
    end
  end

  dsl_mask_lane #(
    .LANES(LANES)
  ) u_mask (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .beatValid(strobeSync),
    .dataMask(maskSync),
    .laneWrite(laneWrite)
  );
endmodule
`default_nettype wire

// ### hdl/dsl_pkg.sv
package dsl_pkg;

  // Command encodings {csN, rasN, casN, weN}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam int A10_BIT = 10;
  localparam int BURST_LEN = 4;
  localparam int CKE_HOLD_CLKS = 3;
  localparam int XSRD_CLKS = 200;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 14;

  typedef enum logic [3:0] {
    DSL_IDLE = 4'h0,
    DSL_ACTIVE = 4'h1,
    DSL_READ = 4'h2,
    DSL_WRITE = 4'h3,
    DSL_PDN_PRE = 4'h4,
    DSL_PDN_ACT = 4'h5,
    DSL_SELF_REF = 4'h6
  } dsl_state_e;

  typedef enum logic [3:0] {
    ACT_NONE = 4'h0,
    ACT_ROW_OPEN = 4'h1,
    ACT_PRECHARGE = 4'h2,
    ACT_READ = 4'h3,
    ACT_WRITE = 4'h4,
    ACT_REFRESH = 4'h5,
    ACT_MODE_SET = 4'h6,
    ACT_PDN_ENTRY = 4'h7,
    ACT_PDN_EXIT = 4'h8,
    ACT_SREF_ENTRY = 4'h9,
    ACT_SREF_EXIT = 4'ha,
    ACT_BURST_INT = 4'hb
  } dsl_action_e;

  typedef struct packed {
    logic cke;
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } dsl_cmd_s;

  typedef struct packed {
    dsl_action_e action;
    logic [BANK_W-1:0] bank;
    logic allBanks;
    logic illegal;
  } dsl_result_s;

endpackage

// ### hdl/dsl_mask_lane.sv
`timescale 1ns/1ns
`default_nettype none
module dsl_mask_lane #(
  parameter int LANES = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic beatValid,
  input wire logic [LANES-1:0] dataMask,
  output logic [LANES-1:0] laneWrite
);
  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      // Beat stored when mask low with valid strobe
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          laneWrite[i] <= 1'b0;
        end else if (clkEn) begin
          laneWrite[i] <= beatValid & ~dataMask[i]; // [RQ15]
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ### bench/dsl_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
module dsl_ctl_model #(
  parameter int LANES = 2
) (
  output var dsl_pkg::dsl_cmd_s pins,
  output logic odtPin,
  output logic strobePin,
  output logic [LANES-1:0] maskPin
);
  logic ckeLast = 1'b1;
  initial begin
    pins = '0;
    pins.cke = 1'b1;
    pins.rasN = 1'b1;
    pins.casN = 1'b1;
    pins.weN = 1'b1;
    odtPin = 1'b0;
    strobePin = 1'b0;
    maskPin = '0;
  end
  task automatic issue(input logic k, input logic [3:0] c, input logic a10);
    logic [3:0] cc;
    cc = c;
    if (!k && !ckeLast) cc = 4'($urandom); // Inputs ignored while low
    else if (k != ckeLast && cc != dsl_pkg::CMD_REF) cc = dsl_pkg::CMD_NOP;
    if (cc[3]) cc[2:0] = 3'($urandom);
    pins = {k, cc, 2'($urandom), 14'($urandom)};
    pins.addr[dsl_pkg::A10_BIT] = a10;
    odtPin = 1'($urandom); // Always a valid level
    strobePin = 1'($urandom); // Mask travels with its beat
    maskPin = LANES'($urandom);
    ckeLast = k;
  endtask
endmodule
`default_nettype wire

// ### bench/dsl_state_legality_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dsl_state_legality_chk #(
  parameter int XSRD_CLKS = 200,
  parameter int LANES = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire dsl_pkg::dsl_cmd_s cmdIn,
  input wire logic odtIn,
  input wire logic strobeValid,
  input wire logic [LANES-1:0] dataMask,
  input wire dsl_pkg::dsl_result_s result,
  input wire logic actionValid,
  input wire dsl_pkg::dsl_state_e stateOut,
  input wire logic odtActive,
  input wire logic readBlocked,
  input wire logic [LANES-1:0] laneWrite
);
  logic [2:0] upCnt;
  logic [15:0] blkCnt;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) upCnt <= 3'h0;
    else if (upCnt != 3'h7) upCnt <= upCnt + 3'h1;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) blkCnt <= 16'h0;
    else blkCnt <= readBlocked ? blkCnt + 16'h1 : 16'h0;
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  mask_lane_a: assert property (upCnt == 3'h7 && $past(clkEn, 3) |->
    laneWrite == ({LANES{$past(strobeValid, 3)}} & ~$past(dataMask, 3)))
    else $error("lane write not mask gated");
  valid_flag_a: assert property (
    actionValid == (result.action != dsl_pkg::ACT_NONE || result.illegal))
    else $error("action valid mismatch");
  hold_low_a: assert property (upCnt == 3'h7 && !$past(cmdIn.cke, 3) &&
    !$past(cmdIn.cke, 4) && $past(stateOut) inside
    {dsl_pkg::DSL_PDN_PRE, dsl_pkg::DSL_PDN_ACT, dsl_pkg::DSL_SELF_REF} |->
    stateOut == $past(stateOut) && result.action == dsl_pkg::ACT_NONE && !result.illegal)
    else $error("low state left while clock enable low");
  pdn_kind_a: assert property (result.action == dsl_pkg::ACT_PDN_ENTRY |->
    stateOut inside {dsl_pkg::DSL_PDN_PRE, dsl_pkg::DSL_PDN_ACT} &&
    (stateOut == dsl_pkg::DSL_PDN_ACT) == ($past(stateOut) == dsl_pkg::DSL_ACTIVE))
    else $error("wrong power down kind");
  sref_idle_a: assert property (stateOut == dsl_pkg::DSL_SELF_REF &&
    $past(stateOut) != dsl_pkg::DSL_SELF_REF |-> $past(stateOut) == dsl_pkg::DSL_IDLE &&
    result.action == dsl_pkg::ACT_SREF_ENTRY)
    else $error("self refresh entered from non idle");
  odt_sref_a: assert property (stateOut == dsl_pkg::DSL_SELF_REF &&
    $past(stateOut) == dsl_pkg::DSL_SELF_REF |-> !odtActive)
    else $error("termination active in self refresh");
  xsrd_len_a: assert property ($fell(readBlocked) |-> blkCnt == 16'(XSRD_CLKS - 1))
    else $error("read block window length wrong");
  read_start_a: assert property (result.action == dsl_pkg::ACT_READ |->
    stateOut == dsl_pkg::DSL_READ && $past(stateOut) == dsl_pkg::DSL_ACTIVE)
    else $error("read started outside active");
  illegal_hold_a: assert property (result.illegal && $past(stateOut) inside
    {dsl_pkg::DSL_IDLE, dsl_pkg::DSL_ACTIVE} |->
    stateOut == $past(stateOut) && result.action == dsl_pkg::ACT_NONE)
    else $error("illegal command changed state");
endmodule
bind dsl_state_legality dsl_state_legality_chk #(.XSRD_CLKS(XSRD_CLKS), .LANES(LANES)) u_chk (
  .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .cmdIn(cmdIn), .odtIn(odtIn),
  .strobeValid(strobeValid), .dataMask(dataMask), .result(result),
  .actionValid(actionValid), .stateOut(stateOut), .odtActive(odtActive),
  .readBlocked(readBlocked), .laneWrite(laneWrite));
`default_nettype wire

// ### bench/dsl_state_legality_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dsl_state_legality_tb;
  localparam int XS = 8;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  dsl_pkg::dsl_cmd_s cmdPins;
  logic odtPin;
  logic strobePin;
  logic [1:0] maskPin;
  logic [1:0] laneWrite;
  dsl_pkg::dsl_result_s result;
  logic actionValid;
  logic odtActive;
  logic readBlocked;
  dsl_pkg::dsl_state_e stateOut;
  dsl_pkg::dsl_state_e st = dsl_pkg::DSL_IDLE;
  logic [11:0] eq[4] = '{default: 12'h0};
  logic ckeP = 1'b1;
  logic [3:0] c;
  int xw = 0;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  dsl_ctl_model u_dsl_ctl_model (.pins(cmdPins), .odtPin(odtPin), .strobePin(strobePin),
    .maskPin(maskPin));
  dsl_state_legality #(.XSRD_CLKS(XS)) u_dsl_state_legality (.core_clk(core_clk),
    .reset_n(reset_n), .clkEn(1'b1), .cmdIn(cmdPins), .odtIn(odtPin),
    .strobeValid(strobePin), .dataMask(maskPin), .result(result), .actionValid(actionValid),
    .stateOut(stateOut), .odtActive(odtActive), .readBlocked(readBlocked),
    .laneWrite(laneWrite));
  always #5 core_clk = ~core_clk;
  task automatic summarize();
    if (mismatches == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected {illegal, action, state} for one command
  function automatic logic [8:0] predict(input logic k, input logic [3:0] cc, input logic a10);
    logic nop;
    logic [8:0] r;
    nop = cc[3] || cc == dsl_pkg::CMD_NOP;
    r = {!nop, dsl_pkg::ACT_NONE, st};
    if (!ckeP) begin
      if (!k) r = {1'b0, dsl_pkg::ACT_NONE, st};
      else if (st == dsl_pkg::DSL_SELF_REF) r[7:0] = {dsl_pkg::ACT_SREF_EXIT, dsl_pkg::DSL_IDLE};
      else if (st == dsl_pkg::DSL_PDN_ACT) r[7:0] = {dsl_pkg::ACT_PDN_EXIT, dsl_pkg::DSL_ACTIVE};
      else r[7:0] = {dsl_pkg::ACT_PDN_EXIT, dsl_pkg::DSL_IDLE};
    end else if (!k) begin
      if (nop) r[7:0] = {dsl_pkg::ACT_PDN_ENTRY,
        st == dsl_pkg::DSL_ACTIVE ? dsl_pkg::DSL_PDN_ACT : dsl_pkg::DSL_PDN_PRE};
      else if (cc == dsl_pkg::CMD_REF && st == dsl_pkg::DSL_IDLE)
        r = {1'b0, dsl_pkg::ACT_SREF_ENTRY, dsl_pkg::DSL_SELF_REF};
    end else if (st == dsl_pkg::DSL_IDLE) begin
      if (cc == dsl_pkg::CMD_ACT) r = {1'b0, dsl_pkg::ACT_ROW_OPEN, dsl_pkg::DSL_ACTIVE};
      if (cc == dsl_pkg::CMD_PRE) r = {1'b0, dsl_pkg::ACT_PRECHARGE, st};
      if (cc == dsl_pkg::CMD_REF) r = {1'b0, dsl_pkg::ACT_REFRESH, st};
      if (cc == dsl_pkg::CMD_MRS) r = {1'b0, dsl_pkg::ACT_MODE_SET, st};
    end else if (st == dsl_pkg::DSL_ACTIVE) begin
      if (cc == dsl_pkg::CMD_RD && xw == 0) r = {1'b0, dsl_pkg::ACT_READ, dsl_pkg::DSL_READ};
      if (cc == dsl_pkg::CMD_WR) r = {1'b0, dsl_pkg::ACT_WRITE, dsl_pkg::DSL_WRITE};
      if (cc == dsl_pkg::CMD_PRE && a10) r = {1'b0, dsl_pkg::ACT_PRECHARGE, dsl_pkg::DSL_IDLE};
    end else if (cc == (st == dsl_pkg::DSL_READ ? dsl_pkg::CMD_RD : dsl_pkg::CMD_WR)) begin
      r = {1'b0, dsl_pkg::ACT_BURST_INT, st};
    end
    return r;
  endfunction
  task automatic step(input logic k, input logic [3:0] cc, input logic a10, input bit chk);
    logic [8:0] r;
    u_dsl_ctl_model.issue(k, cc, a10);
    r = predict(k, {cmdPins.csN, cmdPins.rasN, cmdPins.casN, cmdPins.weN}, a10);
    ckeP = k;
    xw = (r[7:4] == dsl_pkg::ACT_SREF_EXIT) ? XS - 1 : (xw > 0 ? xw - 1 : 0);
    st = dsl_pkg::dsl_state_e'(r[3:0]);
    for (int i = 3; i > 0; i--) eq[i] = eq[i-1];
    eq[0] = {chk, r, cmdPins.bank};
    if (eq[3][11]) begin
      cmp(16'({result.illegal, result.action, stateOut}), 16'(eq[3][10:2]));
      if (eq[3][9:6] == dsl_pkg::ACT_ROW_OPEN) cmp(16'(result.bank), 16'(eq[3][1:0]));
    end
    @(posedge core_clk);
    #1;
  endtask
  task automatic pad(input int n);
    repeat (n) step(1'b1, dsl_pkg::CMD_NOP, 1'b0, 1'b0); // No power change mid burst
    st = dsl_pkg::DSL_ACTIVE;
  endtask
  initial begin
    void'($urandom(32'h9c50));
    repeat (16) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    repeat (4) step(1'b1, dsl_pkg::CMD_NOP, 1'b0, 1'b0);
    for (int i = 0; i < 40; i++) begin
      c = 4'($urandom);
      if (c == dsl_pkg::CMD_ACT) c = dsl_pkg::CMD_NOP;
      step(1'b1, c, 1'($urandom), 1'b1);
    end
    step(1'b1, dsl_pkg::CMD_ACT, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_ACT, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_REF, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_MRS, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_RD, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_WR, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_RD, 1'b0, 1'b1);
    pad(6);
    step(1'b1, dsl_pkg::CMD_WR, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_RD, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_WR, 1'b0, 1'b1);
    pad(6);
    repeat (4) step(1'b0, dsl_pkg::CMD_NOP, 1'b0, 1'b1);
    repeat (3) step(1'b1, dsl_pkg::CMD_NOP, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_PRE, 1'b1, 1'b1);
    repeat (4) step(1'b0, dsl_pkg::CMD_NOP, 1'b0, 1'b1);
    repeat (3) step(1'b1, dsl_pkg::CMD_NOP, 1'b0, 1'b1);
    step(1'b0, dsl_pkg::CMD_REF, 1'b0, 1'b1);
    repeat (4) step(1'b0, dsl_pkg::CMD_NOP, 1'b0, 1'b1);
    cmp(16'(odtActive), 16'h0);
    repeat (4) step(1'b1, dsl_pkg::CMD_NOP, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_ACT, 1'b0, 1'b1);
    step(1'b1, dsl_pkg::CMD_RD, 1'b0, 1'b1);
    cmp(16'(readBlocked), 16'h1);
    repeat (10) step(1'b1, dsl_pkg::CMD_NOP, 1'b0, 1'b1);
    cmp(16'(readBlocked), 16'h0);
    step(1'b1, dsl_pkg::CMD_RD, 1'b0, 1'b1);
    pad(6);
    step(1'b1, dsl_pkg::CMD_PRE, 1'b1, 1'b1);
    repeat (4) step(1'b1, dsl_pkg::CMD_NOP, 1'b0, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
